//--- rtl/mdd_driver_mode_decoder.sv
// driver mode decoder with apb registers and charge pump sequencer
//
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "mdd_map.svh"

module mdd_driver_mode_decoder
  import mdd_pkg::*;
#(
  parameter int PUMP_DIV = `MDD_PUMP_DIV
) (
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // driver pin enables, index 0..6: sd tr rs rl ll st tt; low = driving
  output logic      [6:0]  DRV_INV_OE_N,
  output logic      [6:0]  DRV_NONINV_OE_N,
  // receiver mode passed on to receiver decoder
  output logic      [3:0]  RECEIVER_MODE_SELECT,
  // charge pump phase and switch setting
  output logic      [1:0]  PUMP_PHASE,
  output logic             PUMP_SWITCH_XFER
);

  localparam int NDRV = 7;
  localparam int IDX_SD = 0;
  localparam int IDX_TR = 1;
  localparam int IDX_RS = 2;
  localparam int IDX_RL = 3;
  localparam int IDX_LL = 4;
  localparam int IDX_ST = 5;
  localparam int IDX_TT = 6;

  logic [31:0]   ctrl_q;
  logic [15:0]   div_q;
  logic          tick;
  mdd_phase_type phase_q;
  logic [3:0]    driver_mode_select;
  logic          send_timing_enable_n;
  logic          terminal_timing_enable_n;
  mdd_drive_type drv_type [NDRV];
  logic [6:0]    inv_oe_n_d;
  logic [6:0]    noninv_oe_n_d;
  logic          wr_en;
  logic          rd_en;
  logic          addr_ok;

  // fields of the static selection word
  assign driver_mode_select       = ctrl_q[`MDD_CTRL_DRV_LSB +: 4];
  assign send_timing_enable_n     = ctrl_q[`MDD_CTRL_ST_EN_N];
  assign terminal_timing_enable_n = ctrl_q[`MDD_CTRL_TT_EN_N];

  // role of each driver for a given mode code
  function automatic mdd_drive_type drive_of(input logic [3:0] code, input int idx);
    unique case (code)
      `MDD_CODE_RS232:  drive_of = DRV_SINGLE;
      `MDD_CODE_V35:    drive_of = (idx == IDX_SD || idx == IDX_ST || idx == IDX_TT)
                                   ? DRV_DIFF : DRV_SINGLE;
      `MDD_CODE_RS422,
      `MDD_CODE_RS485:  drive_of = DRV_DIFF;
      `MDD_CODE_RS449,
      `MDD_CODE_EIA530: drive_of = (idx == IDX_RL || idx == IDX_LL)
                                   ? DRV_SINGLE : DRV_DIFF;
      default:          drive_of = DRV_OFF;
    endcase
  endfunction

  // apb access decode; slave answers with no wait states
  assign wr_en   = PSEL && PENABLE && PWRITE;
  assign rd_en   = PSEL && !PENABLE && !PWRITE;
  assign addr_ok = (PADDR == `MDD_CTRL_ADDR) || (PADDR == `MDD_STAT_ADDR) ||
                   (PADDR == `MDD_PHASE_ADDR);

  // control register: the selection word, held until rewritten (no decode latch)
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      ctrl_q <= `MDD_CTRL_RESET;
    end else if (wr_en && PADDR == `MDD_CTRL_ADDR) begin
      ctrl_q <= {22'h0, PWDATA[9:0]};
    end
  end

  // ready and error responses
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !addr_ok;
    end
  end

  // read data captured in setup cycle, valid in access phase
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      PRDATA <= 32'h0;
    end else if (rd_en) begin
      unique case (PADDR)
        `MDD_CTRL_ADDR:  PRDATA <= ctrl_q;
        `MDD_STAT_ADDR:  PRDATA <= {18'h0, DRV_NONINV_OE_N, DRV_INV_OE_N};
        `MDD_PHASE_ADDR: PRDATA <= {29'h0, PUMP_SWITCH_XFER, PUMP_PHASE};
        default:         PRDATA <= 32'h0;
      endcase
    end
  end

  // per-driver type from the mode code
  always_comb begin
    for (int i = 0; i < NDRV; i++) begin
      drv_type[i] = drive_of(driver_mode_select, i);
    end
  end

  // pin enables: inverted pin for any active type, non-inverted only when differential
  always_comb begin
    for (int i = 0; i < NDRV; i++) begin
      inv_oe_n_d[i]    = (drv_type[i] == DRV_OFF);
      noninv_oe_n_d[i] = (drv_type[i] != DRV_DIFF);
    end
    // timing drivers add their own active-low enable
    if (send_timing_enable_n) begin
      inv_oe_n_d[IDX_ST]    = 1'b1;
      noninv_oe_n_d[IDX_ST] = 1'b1;
    end
    if (terminal_timing_enable_n) begin
      inv_oe_n_d[IDX_TT]    = 1'b1;
      noninv_oe_n_d[IDX_TT] = 1'b1;
    end
  end

  // registered driver enables and receiver mode
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      DRV_INV_OE_N         <= 7'h7f;
      DRV_NONINV_OE_N      <= 7'h7f;
      RECEIVER_MODE_SELECT <= 4'h0;
    end else begin
      DRV_INV_OE_N         <= inv_oe_n_d;
      DRV_NONINV_OE_N      <= noninv_oe_n_d;
      RECEIVER_MODE_SELECT <= ctrl_q[`MDD_CTRL_RCV_LSB +: 4];
    end
  end

  // phase tick divider: four phases per pump cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      div_q <= 16'h0;
      tick  <= 1'b0;
    end else if (div_q == 16'(PUMP_DIV - 1)) begin
      div_q <= 16'h0;
      tick  <= 1'b1;
    end else begin
      div_q <= div_q + 16'h1;
      tick  <= 1'b0;
    end
  end

  // free-running phase sequencer
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      phase_q <= PH_NEG_STORE;
    end else if (tick) begin
      unique case (phase_q)
        PH_NEG_STORE: phase_q <= PH_NEG_XFER;
        PH_NEG_XFER:  phase_q <= PH_POS_STORE;
        PH_POS_STORE: phase_q <= PH_POS_XFER;
        PH_POS_XFER:  phase_q <= PH_NEG_STORE;
      endcase
    end
  end

  // phase outputs; storage phases share one switch setting
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      PUMP_PHASE       <= 2'h0;
      PUMP_SWITCH_XFER <= 1'b0;
    end else begin
      PUMP_PHASE       <= phase_q;
      PUMP_SWITCH_XFER <= (phase_q == PH_NEG_XFER) || (phase_q == PH_POS_XFER);
    end
  end

  // rate limits are analog properties; kept here as documentation constants
  localparam int DIFF_MAX_BPS = `MDD_DIFF_MAX_BPS;
  localparam int SE_MAX_BPS   = `MDD_SE_MAX_BPS;

  // assertions
  off_code_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($past(driver_mode_select) == `MDD_CODE_OFF) |->
      (DRV_INV_OE_N == 7'h7f && DRV_NONINV_OE_N == 7'h7f))
    else $error("drivers not tri-stated for code zero");
  rs232_mode_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($past(driver_mode_select) == `MDD_CODE_RS232) |-> DRV_NONINV_OE_N == 7'h7f)
    else $error("rs-232 drove a non-inverted pin");
  v35_mode_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($past(driver_mode_select) == `MDD_CODE_V35) |->
      (DRV_NONINV_OE_N[4:1] == 4'hf && DRV_INV_OE_N[4:0] == 5'h00))
    else $error("v.35 driver roles wrong");
  diff_mode_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($past(driver_mode_select) inside {`MDD_CODE_RS422, `MDD_CODE_RS485}) |->
      (DRV_NONINV_OE_N[4:0] == 5'h00 && DRV_INV_OE_N[4:0] == 5'h00))
    else $error("rs-422/485 pair not differential");
  loop_single_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($past(driver_mode_select) inside {`MDD_CODE_RS449, `MDD_CODE_EIA530}) |->
      (DRV_NONINV_OE_N[4:3] == 2'h3 && DRV_INV_OE_N[4:3] == 2'h0))
    else $error("loopback drivers not single-ended");
  rs449_diff_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($past(driver_mode_select) inside {`MDD_CODE_RS449, `MDD_CODE_EIA530}) |->
      (DRV_NONINV_OE_N[2:0] == 3'h0))
    else $error("rs-449 data drivers not differential");
  st_enable_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    $past(send_timing_enable_n) |-> (DRV_INV_OE_N[IDX_ST] && DRV_NONINV_OE_N[IDX_ST]))
    else $error("send timing driven while disabled");
  tt_enable_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    $past(terminal_timing_enable_n) |-> (DRV_INV_OE_N[IDX_TT] && DRV_NONINV_OE_N[IDX_TT]))
    else $error("terminal timing driven while disabled");
  phase_order_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    tick |=> (phase_q == mdd_phase_type'(2'($past(phase_q) + 2'h1))))
    else $error("pump phase out of order");
  phase_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !tick |=> $stable(phase_q))
    else $error("pump phase moved without tick");
  switch_same_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (phase_q == PH_POS_STORE) |=> !PUMP_SWITCH_XFER)
    else $error("phase three switches differ from phase one");

  // the pump cycle closes back on the first phase
  phase_wrap_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (tick && phase_q == PH_POS_XFER) |=> (phase_q == PH_NEG_STORE))
    else $error("pump phase did not restart after phase four");

  // divider: a tick only ever follows a counter wrap, and never two in a row
  tick_wrap_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    tick |-> (div_q == 16'h0))
    else $error("phase tick without divider wrap");
  tick_single_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    tick |=> !tick)
    else $error("phase tick lasted more than one clock");

  // receiver field is passed on one clock after the selection word
  rcv_copy_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    RECEIVER_MODE_SELECT == $past(ctrl_q[`MDD_CTRL_RCV_LSB +: 4]))
    else $error("receiver mode field not passed on");

  // a control write lands in the selection word at the access edge
  ctrl_write_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (wr_en && PADDR == `MDD_CTRL_ADDR) |=> (ctrl_q[9:0] == $past(PWDATA[9:0])))
    else $error("control write did not land");

  // single-ended rs-232 still drives the inverted pins of drivers sd through ll
  rs232_inv_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    ($past(driver_mode_select) == `MDD_CODE_RS232) |-> (DRV_INV_OE_N[4:0] == 5'h00))
    else $error("rs-232 inverted pin not driven");

  // codes outside the listed set leave every pin tri-stated
  unlisted_off_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !($past(driver_mode_select) inside {`MDD_CODE_RS232, `MDD_CODE_V35,
      `MDD_CODE_RS422, `MDD_CODE_RS485, `MDD_CODE_RS449, `MDD_CODE_EIA530}) |->
      (DRV_INV_OE_N == 7'h7f && DRV_NONINV_OE_N == 7'h7f))
    else $error("unlisted code drove a pin");

  // a low enable lets the timing drivers follow the mode
  st_on_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (!$past(send_timing_enable_n) && $past(driver_mode_select) == `MDD_CODE_RS422) |->
      (!DRV_INV_OE_N[IDX_ST] && !DRV_NONINV_OE_N[IDX_ST]))
    else $error("send timing not driven while enabled");
  tt_on_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (!$past(terminal_timing_enable_n) && $past(driver_mode_select) == `MDD_CODE_RS422) |->
      (!DRV_INV_OE_N[IDX_TT] && !DRV_NONINV_OE_N[IDX_TT]))
    else $error("terminal timing not driven while enabled");

  // bus answer comes one clock after every setup cycle
  ready_setup_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (PSEL && !PENABLE) |=> PREADY)
    else $error("no ready after setup cycle");

endmodule

//--- rtl/mdd_map.svh
// register offsets, field positions, codes and timing constants for the driver mode decoder
`ifndef MDD_MAP_SVH
`define MDD_MAP_SVH
// apb register byte addresses
`define MDD_CTRL_ADDR      12'h000
`define MDD_STAT_ADDR      12'h004
`define MDD_PHASE_ADDR     12'h008
// control register fields
`define MDD_CTRL_DRV_LSB   0
`define MDD_CTRL_RCV_LSB   4
`define MDD_CTRL_ST_EN_N   8
`define MDD_CTRL_TT_EN_N   9
`define MDD_CTRL_RESET     32'h0000_0300
// driver mode select codes
`define MDD_CODE_OFF       4'h0
`define MDD_CODE_RS232     4'h2
`define MDD_CODE_V35       4'he
`define MDD_CODE_RS422     4'h4
`define MDD_CODE_RS485     4'h5
`define MDD_CODE_RS449     4'hc
`define MDD_CODE_EIA530    4'hd
// charge pump timing
`define MDD_CLK_HZ         10000000
`define MDD_PUMP_HZ        15000
`define MDD_PUMP_DIV       (`MDD_CLK_HZ / (`MDD_PUMP_HZ * 4))
// signalling rate limits, bits per second
`define MDD_DIFF_MAX_BPS   5000000
`define MDD_SE_MAX_BPS     120000
`endif

//--- rtl/mdd_pkg.sv
// types shared by the driver mode decoder
package mdd_pkg;
  typedef enum logic [1:0] {DRV_OFF, DRV_SINGLE, DRV_DIFF} mdd_drive_type;
  typedef enum logic [1:0] {PH_NEG_STORE, PH_NEG_XFER, PH_POS_STORE, PH_POS_XFER}
    mdd_phase_type;
  typedef enum logic {SW_STORE, SW_XFER} mdd_switch_type;
endpackage

//--- verification/driver_mode_decoder_tb.sv
// self-checking bench for the driver mode decoder
`timescale 1ns/100ps
`include "mdd_map.svh"
`define CHK(n, e, s) begin num_checks++; if ((s) !== (e)) begin error_cnt++; \
  $display("Error %s exp %h got %h", n, e, s); end end
module driver_mode_decoder_tb;
  import mdd_pkg::*;
  localparam int DIV = 2;
  logic        CORE_CLK = 0, RESETN = 0, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, XF, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  logic [6:0]  INV, NON;
  logic [3:0]  RCV;
  logic [1:0]  PH, p;
  int          error_cnt = 0, num_checks = 0, n;
  // clock at 10 mhz
  always #50 CORE_CLK = ~CORE_CLK;
  mdd_driver_mode_decoder #(.PUMP_DIV(DIV)) DUT (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .DRV_INV_OE_N(INV),
    .DRV_NONINV_OE_N(NON), .RECEIVER_MODE_SELECT(RCV), .PUMP_PHASE(PH),
    .PUMP_SWITCH_XFER(XF));
  mdd_host host (.clk(CORE_CLK), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE),
    .paddr(PADDR), .pwdata(PWDATA), .prdata(PRDATA), .pready(PREADY), .pslverr(PSLVERR));
  // expected pin enables for a code and the two timing enables
  function automatic logic [6:0] exp_oe(logic [3:0] c, logic [1:0] en, logic non);
    logic [6:0] v;
    case (c)
      4'h2: v = non ? 7'h7f : 7'h00;
      4'he: v = non ? 7'h1e : 7'h00;
      4'h4, 4'h5: v = 7'h00;
      4'hc, 4'hd: v = non ? 7'h18 : 7'h00;
      default: v = 7'h7f;
    endcase
    return v | {en, 5'h00};
  endfunction
  // one bus transfer; a host timeout ends the run at the report
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    host.xfer(w, a, d, rd, er);
    if (host.timeouts != 0) summarize();
  endtask
  task automatic set_mode(input logic [31:0] d);
    bus(1'b1, `MDD_CTRL_ADDR, d);
    repeat (2) @(posedge CORE_CLK);
    #1;
  endtask
  task automatic t_reset();
    `CHK("inv", 7'h7f, INV)
    `CHK("non", 7'h7f, NON)
    bus(1'b0, `MDD_CTRL_ADDR, 0);
    `CHK("ctrl", 32'h0000_0300, rd)
  endtask
  task automatic t_codes();
    for (int i = 0; i < 16; i++) begin
      set_mode(((15 - i) << 4) | i);
      `CHK("inv", exp_oe(i, 2'b00, 1'b0), INV)
      `CHK("non", exp_oe(i, 2'b00, 1'b1), NON)
      `CHK("rcv", 4'(15 - i), RCV)
      bus(1'b0, `MDD_STAT_ADDR, 0);
      `CHK("stat", {18'h0, exp_oe(i, 2'b00, 1'b1), exp_oe(i, 2'b00, 1'b0)}, rd)
    end
  endtask
  task automatic t_enables();
    for (int e = 0; e < 4; e++) begin
      set_mode((e << 8) | 32'h44);
      `CHK("en inv", exp_oe(4'h4, 2'(e), 1'b0), INV)
      `CHK("en non", exp_oe(4'h4, 2'(e), 1'b1), NON)
    end
  endtask
  task automatic t_unmapped();
    bus(1'b1, 12'h00c, 32'h0000_0002);
    `CHK("slverr", 1'b1, er)
    bus(1'b0, 12'h00c, 0);
    `CHK("rd unmapped", 32'h0, rd)
    bus(1'b0, `MDD_CTRL_ADDR, 0);
    `CHK("ctrl kept", 32'h0000_0344, rd)
  endtask
  task automatic t_pump();
    for (int k = 0; k < 9; k++) begin
      p = PH;
      n = 0;
      do begin
        @(posedge CORE_CLK);
        n++;
      end while (PH === p && n < 50);
      if (n >= 50) begin
        error_cnt++;
        summarize();
      end
      #1;
      if (k > 0) `CHK("pump div", DIV, n)
      `CHK("phase", 2'(p + 1), PH)
      `CHK("switch", PH[0], XF)
    end
  endtask
  task automatic summarize();
    error_cnt += host.timeouts;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RESETN <= 1'b1;
    @(posedge CORE_CLK);
    #1;
    t_reset();
    t_codes();
    t_enables();
    t_unmapped();
    t_pump();
    summarize();
  end
endmodule

//--- verification/mdd_host.sv
// apb host model that sets the decoder mode word
`timescale 1ns/100ps
module mdd_host (
  // clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int timeouts = 0;
  // bus idle at time zero
  initial begin
    psel = 0;
    penable = 0;
    pwrite = 0;
    paddr = 0;
    pwdata = 0;
  end
  // one transfer; the mode word then stays in ctrl until rewritten
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20) timeouts++;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a; // released lines stop showing the old value
    pwdata <= ~d;
  endtask
endmodule
